// file: logic/ppm_pkg.sv
// Constants and types for the port power management block
`default_nettype none
package ppm_pkg;
	// Register byte offsets in configuration space
	localparam logic [11:0] CMD_OFS   = 12'h004;
	localparam logic [11:0] CAP_OFS   = 12'h040;
	localparam logic [11:0] CSR_OFS   = 12'h044;
	localparam logic [11:0] LCTL_OFS  = 12'h078;
	// Capability header values
	localparam logic [7:0]  CAP_ID    = 8'h01;
	localparam logic [7:0]  NEXT_PTR  = 8'h48;
	localparam logic [2:0]  PM_VER    = 3'h3;
	localparam logic [2:0]  AUX_CUR   = 3'h0;
	localparam logic [4:0]  PME_SUP   = 5'h19;
	// Status and control field positions
	localparam int          NSR_BIT   = 3;
	localparam int          PMEEN_BIT = 8;
	localparam int          PMEST_BIT = 15;
	// Power state codes
	localparam logic [1:0]  PS_D0     = 2'h0;
	localparam logic [1:0]  PS_D3     = 2'h3;
	// Values after reset
	localparam logic [2:0]  CMD_RST   = 3'h0;
	localparam logic [1:0]  ASPM_RST  = 2'h0;
	localparam logic        NSR_RST   = 1'b0;
	localparam logic        PMEEN_RST = 1'b0;
	// Device power states
	typedef enum logic [1:0] {
		D0U = 2'b00,
		D0A = 2'b01,
		D3H = 2'b11
	} ppm_dstate_e;
	// Link power states
	typedef enum logic [1:0] {
		LK_L0  = 2'b00,
		LK_L0S = 2'b01,
		LK_L1  = 2'b10,
		LK_L23 = 2'b11
	} ppm_lstate_e;
	// Request kinds seen by the port
	typedef enum logic [2:0] {
		RQ_MEM  = 3'b000,
		RQ_IO   = 3'b001,
		RQ_CFG0 = 3'b010,
		RQ_CFG1 = 3'b011,
		RQ_CPL  = 3'b100
	} ppm_req_e;
endpackage : ppm_pkg
`default_nettype wire

// file: logic/ppm_port.sv
// Per-port power management: device state, link state, PM registers
// Notes on behaviour
// (R1) Writing 11b from D0 enters D3hot
// (R2) Clearing state field in D3hot returns D0uninit
// (R3) Start D0uninit until EEPROM load and training
// (R4) Any command enable bit moves to D0active
// (R5) D3hot: memory and I/O get UR
// (R6) D3hot: Type1 config UR, Type0 completes
// (R7) Upstream port in D3hot enters L1
// (R8) D3hot hot plug or link event raises PME
// (R9) Downstream request or ASPM trigger lowers link
// (R10) Link states allowed by device state
// (R11) L0s: Tx lanes high-Z, Rx low power
// (R12) L1, L2/L3: lanes low power, FC timers held
// (R13) Turn-off message after D3hot reaches L2/L3
// (R14) Capability ID reads 01h
// (R15) Next pointer reads 48h
// (R16) Version field reads 011b
// (R17) PME clock, DSI, D1, D2 bits read zero
// (R18) EEPROM should load auxiliary current as zero
// (R19) PME support bits 31,30,27 set
// (R20) Unsupported state codes written are discarded
// (R21) No-soft-reset bit suppresses internal reset
// (R22) ASPM field gates L0s and L1 entry
// (R23) PME enable gates; status shows PME pending
`timescale 1ns/1ns
`default_nettype none
module ppm_port (
	input  wire logic                clock,        // Core clock, 100 MHz
	input  wire logic                rst_n,        // Power-on reset, active low
	input  wire logic                cfg_req,      // Config access strobe
	input  wire logic                cfg_we,       // 1 write, 0 read
	input  wire logic [11:0]         cfg_addr,     // Byte address, word aligned
	input  wire logic [3:0]          cfg_be,       // Byte enables
	input  wire logic [31:0]         cfg_wdata,    // Write data
	output logic                     cfg_ack,      // Access done pulse
	output logic      [31:0]         cfg_rdata,    // Read data
	input  wire logic                eeprom_done,  // Serial EEPROM load over
	input  wire logic                link_trained, // First training over
	input  wire logic                is_upstream,  // Port faces the root
	input  wire logic                req_valid,    // Request on the port
	input  wire ppm_pkg::ppm_req_e   req_kind,     // Request kind
	output logic                     req_ur,       // Answer as UR
	input  wire logic                hp_event,     // Hot plug event pulse
	input  wire logic                link_event,   // Link state event pulse
	output logic                     pme_msg,      // Send PME message pulse
	input  wire logic                ds_pm_req,    // Downstream PM request
	input  wire logic                aspm_l0s_trig,// Idle, L0s may enter
	input  wire logic                aspm_l1_trig, // Idle, L1 may enter
	input  wire logic                turn_off,     // Turn-off message seen
	input  wire logic                link_wake,    // Link must return to L0
	output ppm_pkg::ppm_dstate_e     dstate,       // Device power state
	output ppm_pkg::ppm_lstate_e     lstate,       // Link power state
	output logic                     phy_tx_hiz,   // Tx lanes high impedance
	output logic                     phy_tx_lp,    // Tx lanes low power
	output logic                     phy_rx_lp,    // Rx lanes low power
	output logic                     fc_hold,      // Flow control timers held
	output logic                     port_reset    // Internal reset pulse
);
	import ppm_pkg::*;

	logic        rst_q1;
	logic        srst_n;
	logic        init_done;
	logic        next_init_done;
	logic [2:0]  cmd;
	logic [2:0]  next_cmd;
	logic [1:0]  aspm;
	logic [1:0]  next_aspm;
	logic        nsr;
	logic        next_nsr;
	logic        pme_en;
	logic        next_pme_en;
	logic        pme_st;
	logic        next_pme_st;
	ppm_dstate_e next_dstate;
	ppm_lstate_e next_lstate;
	logic        next_port_reset;
	logic        next_pme_msg;
	logic        next_req_ur;
	logic [31:0] next_rdata;
	logic        wr;
	logic        ps_wr;
	logic [31:0] cap_word;
	logic [31:0] csr_word;
	logic        next_phy_tx_hiz;
	logic        next_phy_tx_lp;
	logic        next_phy_rx_lp;
	logic        next_fc_hold;

	// Reset release through two flip-flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_q1 <= 1'b0;
			srst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			srst_n <= rst_q1;
		end
	end

	// Read images of the two PM words
	// (R14) (R15) (R16) capability constants
	// (R17) (R19) zero and PME support bits
	assign cap_word = {PME_SUP, 1'b0, 1'b0, AUX_CUR, 1'b0, 1'b0, 1'b0,
		PM_VER, NEXT_PTR, CAP_ID};
	assign csr_word = {16'h0000, pme_st, 6'h00, pme_en, 4'h0, nsr, 1'b0,
		(dstate == D3H) ? PS_D3 : PS_D0};
	assign wr = cfg_req && cfg_we;
	assign ps_wr = wr && (cfg_addr == CSR_OFS) && cfg_be[0];

	// Register file and device state next values
	always_comb begin
		next_init_done  = init_done | (eeprom_done & link_trained);
		next_cmd        = cmd;
		next_aspm       = aspm;
		next_nsr        = nsr;
		next_pme_en     = pme_en;
		next_pme_st     = pme_st;
		next_dstate     = dstate;
		next_port_reset = 1'b0;
		next_rdata      = 32'h0000_0000;
		if (wr && cfg_be[0]) begin
			if (cfg_addr == CMD_OFS)
				next_cmd = cfg_wdata[2:0];
			if (cfg_addr == LCTL_OFS)
				next_aspm = cfg_wdata[1:0];
			if (cfg_addr == CSR_OFS)
				next_nsr = cfg_wdata[NSR_BIT];
		end
		if (wr && cfg_be[1] && (cfg_addr == CSR_OFS)) begin
			next_pme_en = cfg_wdata[PMEEN_BIT];
			if (cfg_wdata[PMEST_BIT])
				next_pme_st = 1'b0; // Write one to clear
		end
		// (R23) status set, wins over clear
		// (R8) events in D3hot raise PME
		if ((dstate == D3H) && pme_en && (hp_event || link_event))
			next_pme_st = 1'b1;
		// (R3) (R4) D0 sub-states
		if ((dstate == D0U) && init_done && (cmd != 3'h0))
			next_dstate = D0A;
		// (R20) only 00b and 11b act; 01b, 10b dropped
		// (R1) enter D3hot from D0
		if (ps_wr && (cfg_wdata[1:0] == PS_D3) && (dstate != D3H))
			next_dstate = D3H;
		// (R2) leave D3hot for D0uninit
		if (ps_wr && (cfg_wdata[1:0] == PS_D0) && (dstate == D3H)) begin
			next_dstate = D0U;
			// (R21) skip internal reset
			if (!nsr) begin
				next_port_reset = 1'b1;
				next_cmd        = CMD_RST;
			end
		end
		// Read data for the addressed word
		if (cfg_req && !cfg_we) begin
			case (cfg_addr)
				CMD_OFS:  next_rdata = {29'h0, cmd};
				CAP_OFS:  next_rdata = cap_word;
				CSR_OFS:  next_rdata = csr_word;
				LCTL_OFS: next_rdata = {30'h0, aspm};
				default:  next_rdata = 32'h0000_0000;
			endcase
		end
		next_pme_msg = next_pme_st & ~pme_st;
	end

	// Register file and device state flip-flops
	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			init_done  <= 1'b0;
			cmd        <= CMD_RST;
			aspm       <= ASPM_RST;
			nsr        <= NSR_RST;
			pme_en     <= PMEEN_RST;
			pme_st     <= 1'b0;
			dstate     <= D0U;
			port_reset <= 1'b0;
			pme_msg    <= 1'b0;
			cfg_ack    <= 1'b0;
			cfg_rdata  <= 32'h0000_0000;
		end else begin
			init_done  <= next_init_done;
			cmd        <= next_cmd;
			aspm       <= next_aspm;
			nsr        <= next_nsr;
			pme_en     <= next_pme_en;
			pme_st     <= next_pme_st;
			dstate     <= next_dstate;
			port_reset <= next_port_reset;
			pme_msg    <= next_pme_msg;
			cfg_ack    <= cfg_req;
			cfg_rdata  <= next_rdata;
		end
	end

	// Request filtering next value
	always_comb begin
		next_req_ur = 1'b0;
		// (R5) (R6) D3hot filter
		if (req_valid && (dstate == D3H)) begin
			case (req_kind)
				RQ_MEM, RQ_IO, RQ_CFG1: next_req_ur = 1'b1;
				default:                next_req_ur = 1'b0;
			endcase
		end
	end

	// Link state next value
	always_comb begin
		next_lstate = lstate;
		case (lstate)
			LK_L0: begin
				if (dstate == D3H) begin
					// (R7) upstream starts L1
					// (R9) downstream request
					if (is_upstream || ds_pm_req)
						next_lstate = LK_L1;
				// (R10) (R22) ASPM gating
				end else if (aspm[1] && aspm_l1_trig) begin
					next_lstate = LK_L1;
				end else if (aspm[0] && aspm_l0s_trig) begin
					next_lstate = LK_L0S;
				end
			end
			LK_L0S: begin
				if (link_wake || (dstate == D3H) || !aspm[0])
					next_lstate = LK_L0;
			end
			LK_L1: begin
				// (R13) turn-off after D3hot
				if ((dstate == D3H) && turn_off)
					next_lstate = LK_L23;
				else if (dstate != D3H && (link_wake || !aspm[1]))
					next_lstate = LK_L0;
			end
			LK_L23: begin
				if (dstate != D3H)
					next_lstate = LK_L0;
			end
			default: next_lstate = LK_L0;
		endcase
		// (R11) L0s lane actions
		next_phy_tx_hiz = (next_lstate == LK_L0S);
		// (R12) deep state lane actions
		next_phy_tx_lp  = (next_lstate == LK_L1) || (next_lstate == LK_L23);
		next_phy_rx_lp  = (next_lstate != LK_L0);
		next_fc_hold    = (next_lstate == LK_L1) || (next_lstate == LK_L23);
	end

	// Link state, UR answer and lane control flip-flops
	always_ff @(posedge clock or negedge srst_n) begin
		if (!srst_n) begin
			lstate     <= LK_L0;
			req_ur     <= 1'b0;
			phy_tx_hiz <= 1'b0;
			phy_tx_lp  <= 1'b0;
			phy_rx_lp  <= 1'b0;
			fc_hold    <= 1'b0;
		end else begin
			lstate     <= next_lstate;
			req_ur     <= next_req_ur;
			phy_tx_hiz <= next_phy_tx_hiz;
			phy_tx_lp  <= next_phy_tx_lp;
			phy_rx_lp  <= next_phy_rx_lp;
			fc_hold    <= next_fc_hold;
		end
	end

	// Checks of the behaviour above
	default clocking cb @(posedge clock); endclocking
	default disable iff (!srst_n);

	property p_d3_entry;
		ps_wr && cfg_wdata[1:0] == PS_D3 && dstate != D3H |=> dstate == D3H;
	endproperty
	a_d3_entry: assert property (p_d3_entry) else $error("no D3hot entry"); // (R1)

	property p_d0_return;
		ps_wr && cfg_wdata[1:0] == PS_D0 && dstate == D3H |=> dstate == D0U;
	endproperty
	a_d0_return: assert property (p_d0_return) else $error("no D0 return"); // (R2)

	property p_uninit;
		!init_done |-> dstate != D0A;
	endproperty
	a_uninit: assert property (p_uninit) else $error("active too early"); // (R3)

	property p_active;
		dstate == D0U && init_done && cmd != 3'h0 && !ps_wr |=> dstate == D0A;
	endproperty
	a_active: assert property (p_active) else $error("no D0active"); // (R4)

	property p_ur;
		req_valid && dstate == D3H && req_kind != RQ_CFG0 && req_kind != RQ_CPL
			|=> req_ur;
	endproperty
	a_ur: assert property (p_ur) else $error("missing UR"); // (R5)

	property p_cfg0;
		req_valid && (req_kind == RQ_CFG0 || req_kind == RQ_CPL) |=> !req_ur;
	endproperty
	a_cfg0: assert property (p_cfg0) else $error("bad UR"); // (R6)

	property p_up_l1;
		is_upstream && dstate == D3H && lstate == LK_L0 |=> lstate == LK_L1;
	endproperty
	a_up_l1: assert property (p_up_l1) else $error("no L1 entry"); // (R7)

	property p_pme;
		dstate == D3H && pme_en && hp_event |=> pme_st ##0 $past(pme_st) || pme_msg;
	endproperty
	a_pme: assert property (p_pme) else $error("no PME"); // (R8)

	property p_l0s_ok;
		$rose(lstate == LK_L0S) |-> $past(aspm[0]) && $past(dstate) != D3H;
	endproperty
	a_l0s_ok: assert property (p_l0s_ok) else $error("L0s not allowed"); // (R10)

	property p_lanes;
		(lstate == LK_L1 || lstate == LK_L23) |-> phy_tx_lp && phy_rx_lp && fc_hold;
	endproperty
	a_lanes: assert property (p_lanes) else $error("lanes not low"); // (R12)

	property p_unsup;
		ps_wr && (cfg_wdata[1:0] == 2'h1 || cfg_wdata[1:0] == 2'h2) && dstate != D0U
			|=> $stable(dstate);
	endproperty
	a_unsup: assert property (p_unsup) else $error("bad state code took"); // (R20)

	property p_nsr;
		ps_wr && cfg_wdata[1:0] == PS_D0 && dstate == D3H |=> port_reset == !$past(nsr);
	endproperty
	a_nsr: assert property (p_nsr) else $error("reset choice wrong"); // (R21)

	property p_cap;
		cfg_req && !cfg_we && cfg_addr == CAP_OFS |=> cfg_ack && cfg_rdata == 32'hc803_4801;
	endproperty
	a_cap: assert property (p_cap) else $error("capability word wrong"); // (R14)

	c_d3: cover property (dstate == D3H ##1 dstate == D0U);
	c_l23: cover property (lstate == LK_L1 ##1 lstate == LK_L23);
	c_l0s: cover property (lstate == LK_L0S);
	c_pme: cover property (pme_msg);
endmodule : ppm_port
`default_nettype wire

// file: verif/ppm_link_partner.sv
// Link partner and root complex model facing one switch port
`timescale 1ns/1ns
`default_nettype none
module ppm_link_partner (
	input  wire logic                 clock,     // Core clock
	input  wire logic                 rst_n,     // Reset, active low
	input  wire ppm_pkg::ppm_dstate_e dstate,    // Port device state
	input  wire ppm_pkg::ppm_lstate_e lstate,    // Port link state
	input  wire logic                 bcast,     // Bench asks for the broadcast
	input  wire logic                 wake,      // Bench asks the link back up
	output logic                      turn_off,  // Turn-off message to the port
	output logic                      link_wake  // Partner wants L0 again
);
	import ppm_pkg::*;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			turn_off <= 1'b0;
			link_wake <= 1'b0;
		end else begin
			turn_off <= bcast && dstate == D3H;
			link_wake <= wake && lstate != LK_L0;
		end
	end
endmodule : ppm_link_partner
`default_nettype wire

// file: verif/tb_port_power_management.sv
// Self-checking bench for the port power management block
`timescale 1ns/1ns
`default_nettype none
module tb_port_power_management;
	import ppm_pkg::*;
	logic        clock, rst_n, cfg_req, cfg_we, cfg_ack, eeprom_done, link_trained, is_upstream;
	logic        req_valid, req_ur, hp_event, link_event, pme_msg, ds_pm_req, l0s_trig, l1_trig;
	logic        turn_off, link_wake, bcast, wake, tx_hiz, tx_lp, rx_lp, fc_hold, port_reset;
	logic [11:0] addr;
	logic [3:0]  be;
	logic [31:0] wdata, rdata, r;
	ppm_req_e    kind;
	ppm_dstate_e dstate;
	ppm_lstate_e lstate;
	int          n_errors, compares, n_ur, n_pme, n_prst, p0;

	ppm_port DUT (.clock(clock), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(addr),
		.cfg_be(be), .cfg_wdata(wdata), .cfg_ack(cfg_ack), .cfg_rdata(rdata), .eeprom_done(eeprom_done),
		.link_trained(link_trained), .is_upstream(is_upstream), .req_valid(req_valid), .req_kind(kind),
		.req_ur(req_ur), .hp_event(hp_event), .link_event(link_event), .pme_msg(pme_msg),
		.ds_pm_req(ds_pm_req), .aspm_l0s_trig(l0s_trig), .aspm_l1_trig(l1_trig), .turn_off(turn_off),
		.link_wake(link_wake), .dstate(dstate), .lstate(lstate), .phy_tx_hiz(tx_hiz), .phy_tx_lp(tx_lp),
		.phy_rx_lp(rx_lp), .fc_hold(fc_hold), .port_reset(port_reset));
	ppm_link_partner partner (.clock(clock), .rst_n(rst_n), .dstate(dstate), .lstate(lstate),
		.bcast(bcast), .wake(wake), .turn_off(turn_off), .link_wake(link_wake));

	// Pulse counters, sampled before each edge lands
	always @(posedge clock) begin
		n_ur += (req_ur === 1'b1);
		n_pme += (pme_msg === 1'b1);
		n_prst += (port_reset === 1'b1);
	end

	task automatic summarize;
		$display("n_errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	// One config access; entered and left at a falling edge
	task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d);
		cfg_req = 1'b1;
		cfg_we = we;
		addr = a;
		be = 4'hf;
		wdata = d;
		@(negedge clock);
		cfg_req = 1'b0;
		chk(cfg_ack, 1'b1, "ack");
		r = rdata;
		@(negedge clock);
	endtask : acc

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		acc(1'b0, a, 32'h0);
		chk(r, exp, what);
	endtask : rd

	task automatic req(input ppm_req_e k, input logic exp);
		int n0;
		n0 = n_ur;
		req_valid = 1'b1;
		kind = k;
		@(negedge clock);
		req_valid = 1'b0;
		cyc(1);
		chk(n_ur - n0, {31'h0, exp}, "ur");
	endtask : req

	task automatic pulse(input logic hp);
		hp_event = hp;
		link_event = !hp;
		cyc(1);
		hp_event = 1'b0;
		link_event = 1'b0;
		cyc(2);
	endtask : pulse

	task automatic t_caps;
		chk({dstate, lstate}, {D0U, LK_L0}, "reset states");
		rd(CAP_OFS, 32'hc8034801, "cap hdr");
		rd(CSR_OFS, 32'h0, "csr reset");
		rd(12'h100, 32'h0, "unmapped");
	endtask : t_caps

	task automatic t_init;
		acc(1'b1, CMD_OFS, 32'h7);
		cyc(3);
		chk(dstate, D0U, "no init");
		eeprom_done = 1'b1;
		cyc(3);
		chk(dstate, D0U, "eeprom only");
		link_trained = 1'b1;
		cyc(3);
		chk(dstate, D0A, "active");
		rd(CMD_OFS, 32'h7, "cmd");
	endtask : t_init

	task automatic t_aspm;
		for (int c = 0; c < 4; c++) begin
			acc(1'b1, LCTL_OFS, c);
			l0s_trig = 1'b1;
			cyc(2);
			chk(lstate, c[0] ? LK_L0S : LK_L0, "l0s");
			chk({tx_hiz, rx_lp}, {2{c[0]}}, "l0s lanes");
			l0s_trig = 1'b0;
			wake = 1'b1;
			cyc(3);
			wake = 1'b0;
			l1_trig = 1'b1;
			cyc(2);
			chk(lstate, c[1] ? LK_L1 : LK_L0, "l1");
			chk({tx_lp, rx_lp, fc_hold}, {3{c[1]}}, "l1 lanes");
			l1_trig = 1'b0;
			wake = 1'b1;
			cyc(3);
			wake = 1'b0;
			chk(lstate, LK_L0, "back to l0");
		end
		acc(1'b1, LCTL_OFS, 32'h0);
	endtask : t_aspm

	task automatic t_d3;
		acc(1'b1, CSR_OFS, 32'h1);
		acc(1'b1, CSR_OFS, 32'h2);
		rd(CSR_OFS, 32'h0, "bad codes");
		chk(dstate, D0A, "stay d0");
		acc(1'b1, CSR_OFS, 32'h3);
		chk(dstate, D3H, "d3hot");
		rd(CSR_OFS, 32'h3, "state d3");
		for (int k = 0; k < 5; k++) begin
			req(ppm_req_e'(k), k != 2 && k != 4);
		end
		ds_pm_req = 1'b1;
		cyc(2);
		chk(lstate, LK_L1, "ds l1");
		chk({tx_lp, rx_lp, fc_hold}, 3'h7, "l1 held");
		bcast = 1'b1;
		cyc(3);
		chk(lstate, LK_L23, "l23");
		chk({tx_lp, rx_lp, fc_hold}, 3'h7, "l23 held");
		p0 = n_pme;
		acc(1'b1, CSR_OFS, 32'h103);
		pulse(1'b1);
		rd(CSR_OFS, 32'h8103, "pme status");
		acc(1'b1, CSR_OFS, 32'h8103);
		rd(CSR_OFS, 32'h103, "pme cleared");
		pulse(1'b0);
		// Event and clear of a set status land on one edge
		fork
			acc(1'b1, CSR_OFS, 32'h8103);
			pulse(1'b1);
		join
		rd(CSR_OFS, 32'h8103, "set beats clear");
		acc(1'b1, CSR_OFS, 32'h8003);
		pulse(1'b1);
		chk(n_pme - p0, 2, "pme count");
	endtask : t_d3

	task automatic t_exit;
		bcast = 1'b0;
		ds_pm_req = 1'b0;
		p0 = n_prst;
		acc(1'b1, CSR_OFS, 32'h0);
		cyc(1);
		chk(dstate, D0U, "d0 uninit");
		chk(n_prst - p0, 1, "reset pulse");
		rd(CMD_OFS, 32'h0, "cmd cleared");
		chk(lstate, LK_L0, "link up");
		acc(1'b1, CMD_OFS, 32'h1);
		is_upstream = 1'b1;
		acc(1'b1, CSR_OFS, 32'hb);
		cyc(1);
		chk(lstate, LK_L1, "up l1");
		acc(1'b1, CSR_OFS, 32'h8);
		cyc(2);
		chk(n_prst - p0, 1, "no reset");
		rd(CMD_OFS, 32'h1, "cmd kept");
	endtask : t_exit

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		{rst_n, cfg_req, cfg_we, eeprom_done, link_trained, is_upstream, req_valid} = '0;
		{hp_event, link_event, ds_pm_req, l0s_trig, l1_trig, bcast, wake} = '0;
		addr = '0;
		be = '0;
		wdata = '0;
		kind = RQ_MEM;
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		cyc(3);
		t_caps;
		t_init;
		t_aspm;
		t_d3;
		t_exit;
		summarize;
	end

	// Cuts a hang short well past the roughly 150 cycles the tests need
	initial begin
		#100000;
		$display("FAIL t=%0t watchdog expired", $time);
		n_errors++;
		summarize;
	end
endmodule : tb_port_power_management
`default_nettype wire
